// File: core/ssrp_pkg.sv
// Operation
// - host holds select low across streamed bytes
// - first byte goes to header address
// - later bytes step address per direction bit
// - direction defaults to descending after reset
// - streaming reads return sequential addresses
// - first read bit launched on 16th fall
// - host expects corruption at maximum symmetric rate
// - host may lengthen low phase pulses 17 onward
// - host may sample with delayed clock
// - host streams bulk gain and phase loads
// - direction bit, 15 address, 8 data, msb first
// - first bit zero writes, one reads
// - both sides latch data on rising edge
// - memory read issued once per byte; the device samples rd_data once per byte, on the falling edge at count 16
package ssrp_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int HDR_BITS = 16;
    localparam logic [14:0] CFG_ADDR = 15'h0000;
    localparam int CFG_ASC_BIT = 5;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int SDO_DELAY_NS = 7;
    localparam int DIV_HALF = 2;
endpackage

// File: core/ssrp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssrp_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    modport dev (input sclk, input cs_n, input sdi, output sdo);
    modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface
`default_nettype wire

// File: core/ssrp_dev.sv
`timescale 1ns/1ps
`default_nettype none
module ssrp_dev (
    ssrp_if.dev lnk,
    input wire logic rst_n,
    output logic [14:0] wr_addr,
    output logic [7:0] wr_data,
    output logic wr_valid,
    output logic [14:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic dir_asc
);
    // link-clocked shift logic; sclk is this end's only clock
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] sh_q, sh_d;
    logic rd_q, rd_d;
    logic [14:0] addr_q, addr_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] obuf_q, obuf_d;
    logic wv_d;
    logic [7:0] wd_d;
    logic [14:0] nxt;
    logic [15:0] hdr;
    // address step per byte by direction bit
    always_comb begin
        nxt = cfg_q[ssrp_pkg::CFG_ASC_BIT] ? addr_q + 15'h0001 : addr_q - 15'h0001;
    end
    always_comb begin
        hdr = {sh_q[14:0], lnk.sdi};
        cnt_d = cnt_q;
        sh_d = hdr;
        rd_d = rd_q;
        addr_d = addr_q;
        cfg_d = cfg_q;
        wv_d = 1'b0;
        wd_d = hdr[7:0];
        if (cnt_q == 5'(ssrp_pkg::HDR_BITS - 1)) begin
            rd_d = hdr[15];
            addr_d = hdr[14:0];
            cnt_d = cnt_q + 5'h01;
        end else if (cnt_q == 5'(ssrp_pkg::HDR_BITS + ssrp_pkg::DATA_W - 1)) begin
            cnt_d = 5'(ssrp_pkg::HDR_BITS);
            addr_d = nxt;
            if (!rd_q) begin
                wv_d = 1'b1;
                if (addr_q == ssrp_pkg::CFG_ADDR) begin
                    cfg_d = hdr[7:0];
                end
            end
        end else begin
            cnt_d = cnt_q + 5'h01;
        end
    end
    // cs high clears bit state; partial byte dropped
    always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            rd_q <= 1'b0;
            addr_q <= 15'h0000;
        end else begin
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
        end
    end
    // configuration survives between frames
    always_ff @(posedge lnk.sclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= ssrp_pkg::CFG_RESET;
            wr_valid <= 1'b0;
            wr_data <= 8'h00;
            wr_addr <= 15'h0000;
        end else begin
            cfg_q <= cfg_d;
            wr_valid <= wv_d;
            wr_data <= wd_d;
            wr_addr <= addr_q;
        end
    end
    assign rd_addr = addr_q;
    assign dir_asc = cfg_q[ssrp_pkg::CFG_ASC_BIT];
    // output shifter launched on falling edge after header
    always_comb begin
        obuf_d = obuf_q;
        if (lnk.cs_n) begin
            obuf_d = 8'h00;
        end else if (rd_q && (cnt_q == 5'(ssrp_pkg::HDR_BITS))) begin
            obuf_d = rd_data;
        end else begin
            obuf_d = {obuf_q[6:0], 1'b0};
        end
    end
    always_ff @(negedge lnk.sclk or negedge rst_n) begin
        if (!rst_n) begin
            obuf_q <= 8'h00;
        end else begin
            obuf_q <= obuf_d;
        end
    end
    assign lnk.sdo = obuf_q[7];
endmodule // ssrp_dev
`default_nettype wire

// File: core/ssrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssrp_host (
    ssrp_if.host lnk,
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic [14:0] cmd_addr,
    input wire logic [3:0] cmd_len,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    typedef enum logic [3:0] {
        SSRP_IDLE = 4'h1, SSRP_LOW = 4'h2, SSRP_HIGH = 4'h4, SSRP_DONE = 4'h8
    } ssrp_st_t;
    ssrp_st_t st_q, st_d;
    logic [1:0] div_q, div_d;
    logic [4:0] bit_q, bit_d;
    logic [3:0] left_q, left_d;
    logic [15:0] sh_q, sh_d;
    logic rd_q, rd_d;
    logic [7:0] rx_q, rx_d;
    logic push;
    logic [7:0] b0_q, b1_q;
    logic [1:0] n_q;
    logic fill_ok;
    assign cmd_ready = (st_q == SSRP_IDLE);
    assign fill_ok = (n_q != 2'd2);
    // need a write byte at each byte boundary of a write frame except after the last byte
    assign in_ready = !rd_q && (st_q == SSRP_HIGH) && (div_q == 2'(ssrp_pkg::DIV_HALF - 1))
        && ((bit_q == 5'h0f) || ((bit_q == 5'h17) && (left_q != 4'h1)));
    // frame engine; sclk divided from clock
    always_comb begin
        st_d = st_q; div_d = div_q; bit_d = bit_q; left_d = left_q;
        sh_d = sh_q; rd_d = rd_q; rx_d = rx_q; push = 1'b0;
        case (st_q)
            SSRP_IDLE: begin
                if (cmd_valid) begin
                    st_d = SSRP_LOW;
                    sh_d = {cmd_read, cmd_addr};
                    rd_d = cmd_read; left_d = cmd_len; bit_d = 5'd0; div_d = 2'd0;
                end
            end
            SSRP_LOW: begin
                div_d = div_q + 2'd1;
                if (div_q == 2'(ssrp_pkg::DIV_HALF - 1)) begin
                    div_d = 2'd0;
                    if (rd_q && bit_q >= 5'd16 && !fill_ok) begin
                        div_d = div_q;
                    end else begin
                        st_d = SSRP_HIGH;
                        rx_d = {rx_q[6:0], lnk.sdo};
                    end
                end
            end
            SSRP_HIGH: begin
                div_d = div_q + 2'd1;
                if (div_q == 2'(ssrp_pkg::DIV_HALF - 1)) begin
                    div_d = 2'd0;
                    if (bit_q == 5'd15 && !rd_q && !in_valid) begin
                        div_d = div_q; // wait for write data
                    end else begin
                        sh_d = {sh_q[14:0], 1'b0};
                        bit_d = bit_q + 5'd1;
                        st_d = SSRP_LOW;
                        if (bit_q == 5'd15 && !rd_q) sh_d = {in_data, 8'h00};
                        if (bit_q == 5'd23) begin
                            bit_d = 5'd16;
                            if (!rd_q) sh_d = {in_data, 8'h00};
                            push = rd_q;
                            left_d = left_q - 4'd1;
                            if (left_q == 4'd1) st_d = SSRP_DONE;
                            else if (!rd_q && !in_valid) st_d = SSRP_DONE;
                        end
                    end
                end
            end
            SSRP_DONE: st_d = SSRP_IDLE;
            default: st_d = SSRP_IDLE;
        endcase
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= SSRP_IDLE; div_q <= 2'd0; bit_q <= 5'd0; left_q <= 4'd0;
            sh_q <= 16'h0000; rd_q <= 1'b0; rx_q <= 8'h00;
        end else begin
            st_q <= st_d; div_q <= div_d; bit_q <= bit_d; left_q <= left_d;
            sh_q <= sh_d; rd_q <= rd_d; rx_q <= rx_d;
        end
    end
    // two-entry read buffer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            b0_q <= 8'h00; b1_q <= 8'h00; n_q <= 2'd0;
        end else begin
            if (out_valid && out_ready) begin
                b0_q <= b1_q;
                if (push) begin
                    if (n_q == 2'd1) b0_q <= rx_q;
                    else b1_q <= rx_q;
                end
                n_q <= n_q - 2'd1 + {1'b0, push};
            end else if (push) begin
                if (n_q == 2'd0) b0_q <= rx_q;
                else b1_q <= rx_q;
                n_q <= n_q + 2'd1;
            end
        end
    end
    assign out_valid = (n_q != 2'd0);
    assign out_data = b0_q;
    assign lnk.cs_n = (st_q == SSRP_IDLE) || (st_q == SSRP_DONE);
    assign lnk.sclk = (st_q == SSRP_HIGH);
    assign lnk.sdi = sh_q[15];
endmodule // ssrp_host
`default_nettype wire

// File: test/ssrp_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssrp_link_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo
);
    logic [7:0] n_q;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // serial clock rises counted within a frame
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) n_q <= 8'h00;
        else n_q <= cs_n ? 8'h00 : n_q + 8'($rose(sclk));
    end
    // link idles with clock low
    a_idle_clk_low: assert property (cs_n |-> !sclk) else $error("sclk high while deselected");
    a_high_two_cycles: assert property ($rose(sclk) |=> sclk ##1 !sclk)
        else $error("sclk high phase not two cycles");
    a_low_min_two: assert property ($fell(sclk) |=> !sclk) else $error("sclk low phase too short");
    a_select_clk_low: assert property ($changed(cs_n) |-> !sclk) else $error("select moved with sclk high");
    a_sdi_held_high: assert property (!cs_n && sclk && $past(sclk) |-> $stable(sdi))
        else $error("sdi moved while sclk high");
    a_sdo_on_fall: assert property ($past(!cs_n) && !cs_n && $changed(sdo) |-> $fell(sclk))
        else $error("sdo moved off a falling edge");
    a_whole_bytes: assert property ($rose(cs_n) |-> n_q >= 8'h18 && n_q[2:0] == 3'h0)
        else $error("frame not header plus whole bytes");
    a_frame_gap: assert property ($rose(cs_n) |=> cs_n) else $error("no idle cycle between frames");
    // main scenarios
    c_three_bytes: cover property ($rose(cs_n) && n_q == 8'h28);
    c_one_byte: cover property ($rose(cs_n) && n_q == 8'h18);
    c_stall: cover property (!cs_n && !sclk [*8]);
endmodule // ssrp_link_monitor
`default_nettype wire

// File: test/spi_streaming_readback_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, a, b); end end
`define WT(c) begin for (k = 0; k == 0 || (k < 9000 && !(c)); k++) @(negedge clock); if (!(c)) begin n_mismatch++; conclude(); end end
module spi_streaming_readback_port_bench;
    logic clock = 0, rst_n = 0, cmd_valid = 0, cmd_read = 0, in_valid = 0, out_ready = 0;
    logic [14:0] cmd_addr = '0, wr_addr, rd_addr;
    logic [3:0] cmd_len = '0;
    logic [7:0] in_data = '0, wr_data, out_data, rd_data;
    logic cmd_ready, in_ready, out_valid, wr_valid, dir_asc;
    logic [22:0] wq[$];
    int n_mismatch = 0, checks = 0, k;
    ssrp_if lnk();
    ssrp_host ssrp_host_i(.lnk(lnk), .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    ssrp_dev ssrp_dev_i(.lnk(lnk), .rst_n(rst_n), .wr_addr(wr_addr), .wr_data(wr_data), .wr_valid(wr_valid),
        .rd_addr(rd_addr), .rd_data(rd_data), .dir_asc(dir_asc));
    ssrp_link_monitor ssrp_link_monitor_i(.clock(clock), .rst_n(rst_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
        .sdi(lnk.sdi), .sdo(lnk.sdo));
    // memory contents seen by reads
    assign rd_data = rd_addr[7:0] ^ 8'ha5;
    initial begin
        forever #12.5 clock = ~clock;
    end
    // written bytes captured from the device
    always @(negedge lnk.sclk) begin
        if (wr_valid === 1'b1) wq.push_back({wr_addr, wr_data});
    end
    task automatic conclude();
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one frame: command, then nw write bytes taken msb byte first
    task automatic frame(input logic rd, input logic [14:0] a, input logic [3:0] n, input int nw,
        input logic [31:0] d);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_addr <= a;
        cmd_len <= n;
        `WT(cmd_ready === 1'b1)
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (int i = 0; i < nw; i++) begin
            in_valid <= 1'b1;
            in_data <= d[31 - 8 * i -: 8];
            `WT(in_ready === 1'b1)
            @(posedge clock);
        end
        in_valid <= 1'b0;
        if (!rd) `WT(lnk.cs_n === 1'b1 && cmd_ready === 1'b1)
    endtask
    // compare captured writes with a stepped address sequence
    task automatic chk_wr(input int n, input logic [14:0] a, input int step, input logic [31:0] d);
        `CHK(wq.size(), n)
        for (int i = 0; i < n && i < wq.size(); i++) `CHK(wq[i], {a + 15'(step * i), d[31 - 8 * i -: 8]})
        wq.delete();
    endtask
    // take one read byte from the buffer
    task automatic take(input logic [7:0] e);
        `WT(out_valid === 1'b1)
        `CHK(out_data, e)
        @(posedge clock);
        out_ready <= 1'b1;
        @(posedge clock);
        out_ready <= 1'b0;
    endtask
    // default descending stream of three bytes
    task automatic t_desc();
        `CHK(dir_asc, 1'b0)
        frame(1'b0, 15'h0123, 4'h3, 3, 32'h11223300);
        chk_wr(3, 15'h0123, -1, 32'h11223300);
    endtask
    // select ascending, then stream two bytes
    task automatic t_asc();
        frame(1'b0, 15'h0000, 4'h1, 1, 32'h20000000);
        chk_wr(1, 15'h0000, 0, 32'h20000000);
        `CHK(dir_asc, 1'b1)
        frame(1'b0, 15'h7fff, 4'h2, 2, 32'ha1b20000);
        chk_wr(2, 15'h7fff, 1, 32'ha1b20000);
    endtask
    // data stops early, frame closes after one byte
    task automatic t_short();
        frame(1'b0, 15'h0200, 4'h3, 1, 32'h77000000);
        chk_wr(1, 15'h0200, 1, 32'h77000000);
    endtask
    // read of five bytes with the receiver stalled
    task automatic t_read();
        frame(1'b1, 15'h0040, 4'h5, 0, 32'h00000000);
        repeat (600) @(posedge clock);
        `CHK(lnk.cs_n, 1'b0)
        for (int i = 0; i < 5; i++) take((8'h40 + 8'(i)) ^ 8'ha5);
        `WT(lnk.cs_n === 1'b1 && cmd_ready === 1'b1)
    endtask
    // second reset restores descending order for reads
    task automatic t_rst();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        `CHK(dir_asc, 1'b0)
        frame(1'b1, 15'h0081, 4'h1, 0, 32'h00000000);
        take(8'h81 ^ 8'ha5);
        frame(1'b1, 15'h0081, 4'h2, 0, 32'h00000000);
        take(8'h81 ^ 8'ha5);
        take(8'h80 ^ 8'ha5);
        `WT(lnk.cs_n === 1'b1 && cmd_ready === 1'b1)
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_desc();
        t_asc();
        t_short();
        t_read();
        t_rst();
        conclude();
    end
endmodule // spi_streaming_readback_port_bench
`default_nettype wire
